// ### sense_pkg.sv
package sense_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CMD      = 6'h00;
  localparam logic [5:0] IDX_STATUS   = 6'h01;
  localparam logic [5:0] IDX_IFCFG    = 6'h02;
  localparam logic [5:0] IDX_BRIDGE   = 6'h03;
  localparam logic [5:0] IDX_TEMP     = 6'h04;
  localparam logic [5:0] IDX_MEM      = 6'h05;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h06;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h07;

  // Command codes
  localparam logic [7:0] CMD_CYCLIC     = 8'hAB;
  localparam logic [7:0] CMD_HALT_LOOP  = 8'hBF;
  localparam logic [7:0] CMD_SINGLE     = 8'hAA;
  localparam logic [7:0] CMD_ENTER_CFG  = 8'hA0;
  localparam logic [7:0] CMD_NORMAL     = 8'hA8;

  // Status byte bits
  localparam int ST_POWERED = 6;
  localparam int ST_BUSY    = 5;
  localparam int ST_CFG     = 3;
  localparam int ST_MEMERR  = 2;
  localparam int ST_SAT     = 0;

  // Interface configuration fields
  localparam int CFG_DSP       = 0;
  localparam int CFG_SLOT_LSB  = 1;
  localparam int CFG_SLOT_MSB  = 3;
  localparam int CFG_PAUSE_LSB = 8;
  localparam int CFG_PAUSE_MSB = 15;
  localparam logic [15:0] IFCFG_RESET = 16'h0000;
  localparam int PAUSE_SCALE = 8;

  // Config memory words
  localparam int MEM_WORDS   = 8;
  localparam int MEM_GAIN    = 0;
  localparam int MEM_OFFSET  = 1;
  localparam int MEM_CALFLAG = 2;
  localparam logic [15:0] GAIN_RESET = 16'h4000;
  localparam int GAIN_FRAC   = 14;

  // Interrupt events
  localparam int EV_W      = 4;
  localparam int EV_CYCLE  = 0;
  localparam int EV_SAT    = 1;
  localparam int EV_MEMREJ = 2;
  localparam int EV_EARLY  = 3;

  localparam int RES_BAD = 31;

  // Converter phase codes
  localparam logic [1:0] ADC_BR_AZ = 2'h0;
  localparam logic [1:0] ADC_BR    = 2'h1;
  localparam logic [1:0] ADC_TP_AZ = 2'h2;
  localparam logic [1:0] ADC_TP    = 2'h3;

  typedef enum logic [2:0] {
    PH_IDLE                         = 3'b000,
    PH_BRIDGE_OFFSET_CAL_PHASE      = 3'b001,
    PH_BRIDGE_CONVERSION_PHASE      = 3'b011,
    PH_TEMPERATURE_OFFSET_CAL_PHASE = 3'b010,
    PH_TEMPERATURE_CONVERSION_PHASE = 3'b110,
    PH_PAUSE                        = 3'b111
  } phase_type;
endpackage

// ### pause_timer.sv
`timescale 1ns/1ps
module pause_timer
  import sense_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              expired_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
  } tmr_type;

  tmr_type t_r;
  tmr_type t_nxt;

  always_comb begin
    t_nxt = t_r;
    if (load_i) begin
      t_nxt.cnt = count_i;
      t_nxt.run = 1'b1;
    end else if (t_r.run) begin
      if (t_r.cnt == '0) begin
        t_nxt.run = 1'b0;
      end else begin
        t_nxt.cnt = t_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign expired_o = t_r.run && (t_r.cnt == '0) && !load_i;
endmodule

// ### result_corrector.sv
`timescale 1ns/1ps
module result_corrector
  import sense_pkg::*;
#(
  parameter int W  = 24,
  parameter int GW = 16
) (
  // Operands
  input  wire logic [W-1:0]  sample_i,
  input  wire logic [W-1:0]  zero_i,
  input  wire logic [GW-1:0] gain_i,
  input  wire logic [GW-1:0] offset_i,
  // Result
  output logic [W-1:0]       value_o,
  output logic               sat_o
);
  localparam int PW = W + GW + 2;
  logic signed [W:0]    diff;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] sum;
  logic signed [PW-1:0] top;
  logic signed [PW-1:0] bot;

  always_comb begin
    diff = $signed({sample_i[W-1], sample_i}) - $signed({zero_i[W-1], zero_i});
    // Widen before multiplying, else the product is cut to the operand width
    prod = PW'(diff) * PW'($signed({1'b0, gain_i}));
    sum  = (prod >>> GAIN_FRAC) + PW'($signed(offset_i));
    top  = PW'({1'b0, {(W-1){1'b1}}});
    bot  = -top - PW'(1);
    sat_o = 1'b0;
    value_o = sum[W-1:0];
    // Clip rather than wrap so an overrange never flips sign
    if (sum > top) begin
      value_o = top[W-1:0];
      sat_o = 1'b1;
    end else if (sum < bot) begin
      value_o = bot[W-1:0];
      sat_o = 1'b1;
    end
  end
endmodule

// ### sensor_measure_command_control.sv
`timescale 1ns/1ps
module sensor_measure_command_control
  import sense_pkg::*;
#(
  parameter int DW = 24
) (
  // Clock and reset
  input  wire logic          CLK_SYS_I,
  input  wire logic          RST_I,
  // APB slave
  input  wire logic          PSEL_I,
  input  wire logic          PENABLE_I,
  input  wire logic          PWRITE_I,
  input  wire logic [7:0]    PADDR_I,
  input  wire logic [31:0]   PWDATA_I,
  output logic [31:0]        PRDATA_O,
  output logic               PREADY_O,
  output logic               PSLVERR_O,
  // Converter
  output logic               ADC_START_O,
  output logic [1:0]         ADC_PHASE_O,
  output logic [2:0]         SETUP_SLOT_O,
  input  wire logic          ADC_DONE_I,
  input  wire logic [DW-1:0] ADC_DATA_I,
  // Interrupt
  output logic               IRQ_O
);
  typedef struct packed {
    phase_type                  phase;
    logic                       cyclic;
    logic                       cfg_mode;
    logic                       mem_err;
    logic                       sat;
    logic [15:0]                ifcfg;
    logic [MEM_WORDS-1:0][15:0] mem;
    logic [2:0]                 mem_addr;
    logic [DW-1:0]              az;
    logic [DW-1:0]              bridge;
    logic [DW-1:0]              temp;
    logic                       bridge_bad;
    logic                       temp_bad;
    logic [EV_W-1:0]            irq_stat;
    logic [EV_W-1:0]            irq_mask;
    logic [31:0]                prdata;
    logic                       slverr;
    logic                       adc_start;
    logic [1:0]                 adc_phase;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  logic            apb_setup;
  logic            apb_done;
  logic            wr;
  logic            rd_setup;
  logic            mapped;
  logic            busy;
  logic            cmd_wr;
  logic [7:0]      code;
  logic            cyc_acc;
  logic            single_acc;
  logic            halt_acc;
  logic            enter_acc;
  logic            normal_acc;
  logic            dsp;
  logic            cal_ok;
  logic            tmr_load;
  logic            tmr_exp;
  logic [15:0]     pause_cnt;
  logic [DW-1:0]   corr_val;
  logic            corr_sat;
  logic [DW-1:0]   proc_val;
  logic            proc_bad;
  logic [7:0]      status_byte;
  logic [31:0]     rd_val;
  logic [EV_W-1:0] ev;

  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_done  = PSEL_I && PENABLE_I;
  assign wr        = apb_done && PWRITE_I;
  assign rd_setup  = apb_setup && !PWRITE_I;
  assign mapped    = (PADDR_I[7:2] <= IDX_IRQ_MASK) && (PADDR_I[1:0] == 2'h0);
  assign busy      = (s_r.phase != PH_IDLE);
  assign cmd_wr    = wr && hit(PADDR_I, IDX_CMD);
  assign code      = PWDATA_I[7:0];
  // Measurements refused in config state and while a run is active
  assign cyc_acc    = cmd_wr && (code == CMD_CYCLIC) && !busy && !s_r.cfg_mode;
  assign single_acc = cmd_wr && (code == CMD_SINGLE) && !busy && !s_r.cfg_mode;
  assign halt_acc   = cmd_wr && (code == CMD_HALT_LOOP) && busy;
  assign enter_acc  = cmd_wr && (code == CMD_ENTER_CFG) && !busy;
  assign normal_acc = cmd_wr && (code == CMD_NORMAL) && s_r.cfg_mode;

  assign dsp    = s_r.ifcfg[CFG_DSP];
  assign cal_ok = s_r.mem[MEM_CALFLAG][0];
  assign pause_cnt = {s_r.ifcfg[CFG_PAUSE_MSB:CFG_PAUSE_LSB], {PAUSE_SCALE{1'b0}}};
  assign tmr_load = (s_r.phase == PH_TEMPERATURE_CONVERSION_PHASE) && ADC_DONE_I
                    && s_r.cyclic && !halt_acc;

  pause_timer #(
    .W (16)
  ) u_timer (
    .clk_i     (CLK_SYS_I),
    .rst_i     (RST_I),
    .load_i    (tmr_load),
    .count_i   (pause_cnt),
    .expired_o (tmr_exp)
  );

  result_corrector #(
    .W  (DW),
    .GW (16)
  ) u_corr (
    .sample_i (ADC_DATA_I),
    .zero_i   (s_r.az),
    .gain_i   (s_r.mem[MEM_GAIN]),
    .offset_i (s_r.mem[MEM_OFFSET]),
    .value_o  (corr_val),
    .sat_o    (corr_sat)
  );

  // Raw path skips offset removal entirely
  assign proc_val = dsp ? corr_val : ADC_DATA_I;
  assign proc_bad = dsp && (corr_sat || !cal_ok);

  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_POWERED] = 1'b1;
    status_byte[ST_BUSY]    = busy;
    status_byte[ST_CFG]     = s_r.cfg_mode;
    status_byte[ST_MEMERR]  = s_r.mem_err;
    status_byte[ST_SAT]     = s_r.sat;
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit(PADDR_I, IDX_STATUS)) begin
      rd_val = {24'h00_0000, status_byte};
    end else if (hit(PADDR_I, IDX_IFCFG)) begin
      rd_val = {16'h0000, s_r.ifcfg};
    end else if (hit(PADDR_I, IDX_BRIDGE)) begin
      rd_val[DW-1:0] = s_r.bridge;
      rd_val[RES_BAD] = s_r.bridge_bad || busy;
    end else if (hit(PADDR_I, IDX_TEMP)) begin
      rd_val[DW-1:0] = s_r.temp;
      rd_val[RES_BAD] = s_r.temp_bad || busy;
    end else if (hit(PADDR_I, IDX_MEM)) begin
      rd_val = {13'h0000, s_r.mem_addr, s_r.mem[s_r.mem_addr]};
    end else if (hit(PADDR_I, IDX_IRQ_STAT)) begin
      rd_val = {28'h000_0000, s_r.irq_stat};
    end else if (hit(PADDR_I, IDX_IRQ_MASK)) begin
      rd_val = {28'h000_0000, s_r.irq_mask};
    end
  end

  always_comb begin
    s_nxt = s_r;
    ev = '0;
    s_nxt.adc_start = 1'b0;
    // Read data and error are captured in setup, shown in access
    if (apb_setup) begin
      s_nxt.prdata = PWRITE_I ? 32'h0000_0000 : rd_val;
      s_nxt.slverr = !mapped;
    end
    if (rd_setup && busy && (hit(PADDR_I, IDX_BRIDGE) || hit(PADDR_I, IDX_TEMP))) begin
      ev[EV_EARLY] = 1'b1;
    end
    if (wr && hit(PADDR_I, IDX_IFCFG)) begin
      s_nxt.ifcfg = PWDATA_I[15:0];
    end
    if (wr && hit(PADDR_I, IDX_IRQ_MASK)) begin
      s_nxt.irq_mask = PWDATA_I[EV_W-1:0];
    end
    if (wr && hit(PADDR_I, IDX_MEM)) begin
      s_nxt.mem_addr = PWDATA_I[18:16];
      if (s_r.cfg_mode) begin
        s_nxt.mem[PWDATA_I[18:16]] = PWDATA_I[15:0];
      end else begin
        s_nxt.mem_err = 1'b1;
        ev[EV_MEMREJ] = 1'b1;
      end
    end
    if (enter_acc) begin
      s_nxt.cfg_mode = 1'b1;
      s_nxt.mem_err = 1'b0;
    end
    if (normal_acc) begin
      s_nxt.cfg_mode = 1'b0;
    end
    case (s_r.phase)
      PH_IDLE: begin
        if (cyc_acc || single_acc) begin
          s_nxt.cyclic = cyc_acc;
          s_nxt.sat = 1'b0;
          s_nxt.phase = PH_BRIDGE_OFFSET_CAL_PHASE;
          s_nxt.adc_start = 1'b1;
          s_nxt.adc_phase = ADC_BR_AZ;
        end
      end
      PH_BRIDGE_OFFSET_CAL_PHASE: begin
        if (ADC_DONE_I) begin
          s_nxt.az = ADC_DATA_I;
          s_nxt.phase = PH_BRIDGE_CONVERSION_PHASE;
          s_nxt.adc_start = 1'b1;
          s_nxt.adc_phase = ADC_BR;
        end
      end
      PH_BRIDGE_CONVERSION_PHASE: begin
        if (ADC_DONE_I) begin
          s_nxt.bridge = proc_val;
          s_nxt.bridge_bad = proc_bad;
          if (dsp && corr_sat) begin
            s_nxt.sat = 1'b1;
            ev[EV_SAT] = 1'b1;
          end
          s_nxt.phase = PH_TEMPERATURE_OFFSET_CAL_PHASE;
          s_nxt.adc_start = 1'b1;
          s_nxt.adc_phase = ADC_TP_AZ;
        end
      end
      PH_TEMPERATURE_OFFSET_CAL_PHASE: begin
        if (ADC_DONE_I) begin
          s_nxt.az = ADC_DATA_I;
          s_nxt.phase = PH_TEMPERATURE_CONVERSION_PHASE;
          s_nxt.adc_start = 1'b1;
          s_nxt.adc_phase = ADC_TP;
        end
      end
      PH_TEMPERATURE_CONVERSION_PHASE: begin
        if (ADC_DONE_I) begin
          s_nxt.temp = proc_val;
          s_nxt.temp_bad = proc_bad;
          if (dsp && corr_sat) begin
            s_nxt.sat = 1'b1;
            ev[EV_SAT] = 1'b1;
          end
          ev[EV_CYCLE] = 1'b1;
          s_nxt.phase = s_r.cyclic ? PH_PAUSE : PH_IDLE;
        end
      end
      PH_PAUSE: begin
        if (tmr_exp) begin
          s_nxt.phase = PH_BRIDGE_OFFSET_CAL_PHASE;
          s_nxt.adc_start = 1'b1;
          s_nxt.adc_phase = ADC_BR_AZ;
        end
      end
      default: begin
        s_nxt.phase = PH_IDLE;
      end
    endcase
    // Halt aborts any conversion in flight; a late done is ignored in idle
    if (halt_acc) begin
      s_nxt.phase = PH_IDLE;
      s_nxt.cyclic = 1'b0;
      s_nxt.adc_start = 1'b0;
    end
    // Clear only what the reader saw, so a fresh event survives
    if (apb_done && !PWRITE_I && hit(PADDR_I, IDX_IRQ_STAT)) begin
      s_nxt.irq_stat = s_r.irq_stat & ~s_r.prdata[EV_W-1:0];
    end
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      s_r <= '0;
      s_r.phase <= PH_IDLE;
      s_r.ifcfg <= IFCFG_RESET;
      s_r.mem[MEM_GAIN] <= GAIN_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA_O     = s_r.prdata;
  assign PSLVERR_O    = s_r.slverr && apb_done;
  assign PREADY_O     = 1'b1;
  assign ADC_START_O  = s_r.adc_start;
  assign ADC_PHASE_O  = s_r.adc_phase;
  assign SETUP_SLOT_O = s_r.ifcfg[CFG_SLOT_MSB:CFG_SLOT_LSB];
  assign IRQ_O        = |(s_r.irq_stat & s_r.irq_mask);

  cyc_busy_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    cyc_acc |=> busy && s_r.cyclic)
    else $error("cyclic start did not raise busy");
  loop_busy_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_r.cyclic && !halt_acc |=> busy)
    else $error("busy dropped during cyclic run");
  halt_idle_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    halt_acc |=> !busy && !s_r.cyclic && !ADC_START_O)
    else $error("halt did not stop the loop");
  phase_order_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_r.phase == PH_BRIDGE_OFFSET_CAL_PHASE && ADC_DONE_I && !halt_acc
    |=> s_r.phase == PH_BRIDGE_CONVERSION_PHASE && ADC_START_O && ADC_PHASE_O == ADC_BR)
    else $error("bridge conversion did not follow its offset phase");
  loop_back_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_r.phase == PH_PAUSE && tmr_exp && !halt_acc
    |=> s_r.phase == PH_BRIDGE_OFFSET_CAL_PHASE && ADC_START_O && ADC_PHASE_O == ADC_BR_AZ)
    else $error("cyclic loop did not restart itself");
  pause_cfg_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    tmr_load |=> s_r.phase == PH_PAUSE
    && (tmr_exp == ($past(s_r.ifcfg[CFG_PAUSE_MSB:CFG_PAUSE_LSB]) == 8'h00)))
    else $error("pause not taken from configuration");
  raw_out_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_r.phase == PH_BRIDGE_CONVERSION_PHASE && ADC_DONE_I && !dsp && !halt_acc
    |=> s_r.bridge == $past(ADC_DATA_I) && !s_r.bridge_bad)
    else $error("raw result altered");
  dsp_uncal_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_r.phase == PH_TEMPERATURE_CONVERSION_PHASE && ADC_DONE_I && dsp && !cal_ok
    |=> s_r.temp_bad)
    else $error("uncalibrated result not flagged");
  mem_gate_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    wr && hit(PADDR_I, IDX_MEM) && !s_r.cfg_mode |=> s_r.mem == $past(s_r.mem) && s_r.mem_err)
    else $error("memory written outside config state");
  early_read_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    rd_setup && busy && hit(PADDR_I, IDX_BRIDGE) |=> PRDATA_O[RES_BAD] && s_r.irq_stat[EV_EARLY])
    else $error("early result read not flagged");
  sat_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_r.phase == PH_BRIDGE_CONVERSION_PHASE && ADC_DONE_I && dsp && corr_sat && !halt_acc
    |=> s_r.sat && s_r.bridge_bad)
    else $error("saturation not reported");
  status_rd_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    rd_setup && hit(PADDR_I, IDX_STATUS)
    |=> PRDATA_O[ST_BUSY] == $past(busy) && PRDATA_O[ST_CFG] == $past(s_r.cfg_mode))
    else $error("status byte wrong");

  two_loops_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    tmr_load ##[1:1000] tmr_load);
  halt_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_r.cyclic && halt_acc);
  mem_write_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    wr && hit(PADDR_I, IDX_MEM) && s_r.cfg_mode);
  early_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    ev[EV_EARLY]);
endmodule

// ### adc_model.sv
`timescale 1ns/1ps
module adc_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Converter request
  input  wire logic        start_i,
  input  wire logic [1:0]  phase_i,
  input  wire logic [7:0]  lat_i,
  input  wire logic        big_i,
  // Converter answer
  output logic             done_o,
  output logic [23:0]      data_o
);
  logic [7:0] cnt;

  function automatic logic [23:0] sample(input logic [1:0] ph, input logic big);
    case (ph)
      2'h0:    sample = 24'h000010;
      2'h1:    sample = big ? 24'h7FFFF0 : 24'h001000;
      2'h2:    sample = 24'h000020;
      default: sample = 24'h002000;
    endcase
  endfunction

  // Data only valid with done; it toggles otherwise so stale reads show
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      cnt    <= 8'h00;
      data_o <= 24'h000000;
    end else if (start_i) begin
      cnt    <= lat_i;
      data_o <= ~data_o;
    end else if (cnt == 8'h01) begin
      cnt    <= 8'h00;
      done_o <= 1'b1;
      data_o <= sample(phase_i, big_i);
    end else begin
      if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      data_o <= ~data_o;
    end
  end
endmodule

// ### sensor_measure_command_control_tb.sv
`timescale 1ns/1ps
module sensor_measure_command_control_tb;
  import sense_pkg::*;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, start, done, irq, big, e;
  logic [7:0]  paddr, lat;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  phase, exp_ph;
  logic [2:0]  slot;
  logic [23:0] data;
  int          err_total, checks, starts, n, cyc, t_last, gap, k;

  sensor_measure_command_control dut_u (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .ADC_START_O(start), .ADC_PHASE_O(phase), .SETUP_SLOT_O(slot),
    .ADC_DONE_I(done), .ADC_DATA_I(data), .IRQ_O(irq));
  adc_model model_u (.clk_i(clk), .rst_i(rst), .start_i(start), .phase_i(phase), .lat_i(lat),
    .big_i(big), .done_o(done), .data_o(data));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict;
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Access waits on pready; no fixed wait-state count assumed
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= {idx, 2'b00}; pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      give_verdict;
    end
  endtask

  task automatic rdc(input string what, input logic [5:0] idx, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, idx, 32'h0);
    chk(what, rd & m, exp);
  endtask

  task automatic cmd(input logic [7:0] code);
    if (code == CMD_CYCLIC || code == CMD_SINGLE) begin
      exp_ph = 2'h0;
    end
    apb(1'b1, IDX_CMD, {24'h0, code});
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, IDX_STATUS, 32'h0);
      k++;
    end while (rd[ST_BUSY] !== 1'b0 && k < 200);
    if (rd[ST_BUSY] !== 1'b0) begin
      err_total++;
      give_verdict;
    end
  endtask

  // Loop order watched on every conversion start
  always @(posedge clk) begin
    cyc++;
    if (start === 1'b1) begin
      chk("phase", {30'h0, phase}, {30'h0, exp_ph});
      exp_ph = exp_ph + 2'h1;
      gap = cyc - t_last;
      t_last = cyc;
      starts++;
    end
  end

  initial begin
    psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    lat = 8'h03; big = 1'b0; rst = 1'b1; exp_ph = 2'h0;
    err_total = 0; checks = 0; starts = 0; cyc = 0; t_last = 0; gap = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc("ifcfg reset", IDX_IFCFG, 32'h0, 32'hFFFFFFFF);
    rdc("status reset", IDX_STATUS, 32'h40, 32'hFF);
    apb(1'b0, 6'h3F, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, IDX_MEM, 32'h00020001);
    rdc("mem refused", IDX_STATUS, 32'h44, 32'hFF);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, IDX_IRQ_MASK, 32'h4);
    @(posedge clk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rdc("irq stat", IDX_IRQ_STAT, 32'h4, 32'hF);
    @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    // Cyclic run: host only polls, never retriggers
    lat <= 8'h05;
    apb(1'b1, IDX_IFCFG, 32'h0);
    cmd(CMD_CYCLIC);
    repeat (20) rdc("busy cyclic", IDX_STATUS, 32'h60, 32'h60);
    rdc("early read", IDX_BRIDGE, 32'h80000000, 32'h80000000);
    chk("loop starts", {31'h0, starts >= 8}, 32'h1);
    cmd(CMD_HALT_LOOP);
    repeat (3) @(posedge clk);
    rdc("busy halted", IDX_STATUS, 32'h0, 32'h20);
    n = starts;
    repeat (30) @(posedge clk);
    chk("halt quiet", {31'h0, starts == n}, 32'h1);
    // Paced loop: one pause unit between cycles
    lat <= 8'h01;
    apb(1'b1, IDX_IFCFG, 32'h00000100);
    n = starts;
    cmd(CMD_CYCLIC);
    k = 0;
    while (starts < n + 5 && k < 600) begin
      @(posedge clk);
      k++;
    end
    if (starts < n + 5) begin
      err_total++;
      give_verdict;
    end
    chk("pause gap", gap, 32'h0000_0004 + (32'h0000_0001 << PAUSE_SCALE));
    cmd(CMD_HALT_LOOP);
    // Raw single on slot 5, prompt converter
    lat <= 8'h01;
    apb(1'b1, IDX_IFCFG, 32'h0000000A);
    @(posedge clk);
    chk("slot", {29'h0, slot}, 32'h5);
    cmd(CMD_SINGLE);
    wait_idle;
    rdc("raw bridge", IDX_BRIDGE, 32'h00001000, 32'hFFFFFFFF);
    rdc("raw temp", IDX_TEMP, 32'h00002000, 32'hFFFFFFFF);
    // Processing before and after calibration, slow converter
    lat <= 8'h14;
    apb(1'b1, IDX_IFCFG, 32'h1);
    cmd(CMD_SINGLE);
    wait_idle;
    rdc("uncal invalid", IDX_BRIDGE, 32'h80000000, 32'h80000000);
    cmd(CMD_ENTER_CFG);
    rdc("cfg state", IDX_STATUS, 32'h48, 32'hFF);
    apb(1'b1, IDX_MEM, 32'h00020001);
    rdc("mem write", IDX_MEM, 32'h00020001, 32'hFFFFFFFF);
    cmd(CMD_NORMAL);
    rdc("normal state", IDX_STATUS, 32'h40, 32'hFF);
    cmd(CMD_SINGLE);
    wait_idle;
    rdc("dsp bridge", IDX_BRIDGE, 32'h00000FF0, 32'hFFFFFFFF);
    rdc("dsp temp", IDX_TEMP, 32'h00001FE0, 32'hFFFFFFFF);
    // Near-double gain on a large sample overflows the 24-bit result
    cmd(CMD_ENTER_CFG);
    apb(1'b1, IDX_MEM, 32'h00007FFF);
    cmd(CMD_NORMAL);
    big <= 1'b1;
    cmd(CMD_SINGLE);
    wait_idle;
    rdc("sat status", IDX_STATUS, 32'h41, 32'hFF);
    rdc("sat invalid", IDX_BRIDGE, 32'h80000000, 32'h80000000);
    rdc("irq events", IDX_IRQ_STAT, 32'hB, 32'hF);
    // Second reset after the runs, with the unit idle, must restore defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc("ifcfg rereset", IDX_IFCFG, 32'h0, 32'hFFFFFFFF);
    rdc("status rereset", IDX_STATUS, 32'h40, 32'hFF);
    give_verdict;
  end
endmodule
